// ==== rtl/modem_format_pkg.sv ====
// constants and types shared by the modem format configuration block
// assumes a single 8-bit configuration register file reached by byte address
package modem_format_pkg;

	// register map
	localparam logic [7:0] MODEM_FMT_ADDR = 8'h12;
	localparam logic [7:0] MODEM_FMT_RESET = 8'h02;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	// field positions inside modem_format_control
	localparam int BYPASS_BIT = 7;
	localparam int MOD_LSB = 4;
	localparam int MANCH_BIT = 3;
	localparam int SYNC_LSB = 0;

	// sync qualifier thresholds
	localparam logic [5:0] SYNC16_LEN = 6'h10;
	localparam logic [5:0] SYNC32_LEN = 6'h20;
	localparam logic [5:0] SYNC16_LOOSE = 6'h0f;
	localparam logic [5:0] SYNC32_LOOSE = 6'h1e;

	typedef enum logic [2:0] {
		MOD_2FSK = 3'h0,
		MOD_GFSK = 3'h1,
		MOD_OOK = 3'h3,
		MOD_4FSK = 3'h4
	} modulation_select_e;

	// base sync criterion in the low two qualifier bits
	typedef enum logic [1:0] {
		SYNC_NONE = 2'h0,
		SYNC_15_16 = 2'h1,
		SYNC_16_16 = 2'h2,
		SYNC_30_32 = 2'h3
	} sync_base_e;

	// field layout matches the register bit order
	typedef struct packed {
		logic dc_block_bypass;
		logic [2:0] modulation_select;
		logic manchester_en;
		logic [2:0] sync_qualifier;
	} modem_format_control_s;

	// manchester phase, one-hot
	typedef enum logic [1:0] {
		HALF_FIRST = 2'b01,
		HALF_SECOND = 2'b10
	} chip_half_e;

endpackage

// ==== rtl/sync_correlator.sv ====
// sliding 32-bit correlator against a 16-bit sync word sent twice
// assumes bits arrive one per strobe, oldest bit shifted out first
`timescale 1ns/1ps
module sync_correlator #(
	parameter int WORD_W = 16
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic bit_in,
	input wire logic bit_valid_in,
	input wire logic [WORD_W-1:0] sync_word_in,
	output logic [5:0] low_match_out,
	output logic [5:0] full_match_out,
	output logic [5:0] fill_out
);
	logic [2*WORD_W-1:0] shift_reg;
	logic [5:0] fill_reg;
	logic [2*WORD_W-1:0] agree;

	// history of received bits, newest in bit 0
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			shift_reg <= '0;
		end else if (bit_valid_in) begin
			shift_reg <= {shift_reg[2*WORD_W-2:0], bit_in};
		end
	end

	// count of bits seen, so a window holding fewer bits than the searched word never qualifies
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			fill_reg <= '0;
		end else if (clear_in) begin
			fill_reg <= '0;
		end else if (bit_valid_in && fill_reg < 6'(2 * WORD_W)) begin
			fill_reg <= fill_reg + 6'h01;
		end
	end

	// per-bit agreement with the doubled word
	genvar i;
	generate
		for (i = 0; i < 2 * WORD_W; i++) begin : g_agree
			assign agree[i] = ~(shift_reg[i] ^ sync_word_in[i % WORD_W]);
		end
	endgenerate

	// population counts of agreeing bits
	always_comb begin
		low_match_out = '0;
		full_match_out = '0;
		for (int k = 0; k < 2 * WORD_W; k++) begin
			if (k < WORD_W) begin
				low_match_out = low_match_out + 6'(agree[k]);
			end
			full_match_out = full_match_out + 6'(agree[k]);
		end
	end

	assign fill_out = fill_reg;
endmodule

// ==== rtl/modem_format_config.sv ====
// modem format configuration register with the logic it steers:
// dc block bypass, modulation select, manchester coding, sync qualifier
// assumes a register port from the serial interface, synchronous to CLK_IN
`timescale 1ns/1ps
// Functional notes
// - bit 7 zero keeps dc block filter active, one bypasses it
// - bits 6:4 select 2-FSK, GFSK, OOK or 4-FSK; other codes reserved
// - bit 3 enables manchester encode and decode; off in async serial mode
// - qualifier 0 or 4 turns sync word detection off
// - qualifier 1,2,5,6 search 16-bit word; 2,6 exact, 1,5 allow 15/16
// - qualifier 3 and 7 search doubled word, at least 30 of 32 match
// - qualifier 4 to 7 additionally require carrier above threshold
module modem_format_config
#(
	parameter int WORD_W = 16
) (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_WDATA_IN,
	output logic [7:0] REG_RDATA_OUT,
	output logic REG_RVALID_OUT,
	output logic DC_BLOCK_BYPASS_OUT,
	output modem_format_pkg::modulation_select_e MODULATION_SELECT_OUT,
	output logic MANCHESTER_EN_OUT,
	input wire logic TX_DATA_IN,
	input wire logic TX_CHIP_STROBE_IN,
	output logic TX_CHIP_OUT,
	output logic TX_DATA_TAKE_OUT,
	input wire logic RX_CHIP_IN,
	input wire logic RX_CHIP_STROBE_IN,
	output logic RX_DATA_OUT,
	output logic RX_DATA_VALID_OUT,
	output logic RX_CODE_ERR_OUT,
	input wire logic [WORD_W-1:0] SYNC_WORD_IN,
	input wire logic CARRIER_ABOVE_IN,
	input wire logic SYNC_RESTART_IN,
	output logic SYNC_SEARCH_OUT,
	output logic SYNC_FOUND_OUT
);
	import modem_format_pkg::*;

	modem_format_control_s ctrl_reg;
	chip_half_e tx_half_reg;
	chip_half_e rx_half_reg;
	logic tx_hold_reg;
	logic rx_first_reg;
	logic rx_bit;
	logic rx_bit_valid;
	logic [5:0] low_match;
	logic [5:0] full_match;
	logic [5:0] fill;
	sync_base_e sync_base;
	logic sync_enabled;
	logic criterion_met;
	logic hit;

	// host register write; reserved codes are stored as written
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ctrl_reg <= modem_format_control_s'(MODEM_FMT_RESET);
		end else if (REG_WR_IN && REG_ADDR_IN == MODEM_FMT_ADDR) begin
			ctrl_reg <= modem_format_control_s'(REG_WDATA_IN);
		end
	end

	// registered read answer, one cycle after the request
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			REG_RDATA_OUT <= READ_UNMAPPED;
			REG_RVALID_OUT <= 1'b0;
		end else begin
			REG_RVALID_OUT <= REG_RD_IN;
			if (REG_RD_IN && REG_ADDR_IN == MODEM_FMT_ADDR) begin
				REG_RDATA_OUT <= ctrl_reg;
			end else if (REG_RD_IN) begin
				REG_RDATA_OUT <= READ_UNMAPPED;
			end
		end
	end

	// configuration fields to the analogue and demodulator sides;
	// the data rate limit on bypass is the host's to keep
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			DC_BLOCK_BYPASS_OUT <= 1'b0;
			MODULATION_SELECT_OUT <= MOD_2FSK;
			MANCHESTER_EN_OUT <= 1'b0;
		end else begin
			DC_BLOCK_BYPASS_OUT <= ctrl_reg.dc_block_bypass;
			MODULATION_SELECT_OUT <=
				modulation_select_e'(ctrl_reg.modulation_select);
			MANCHESTER_EN_OUT <= ctrl_reg.manchester_en;
		end
	end

	// transmit chips: plain, or data then its inverse per bit
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			tx_half_reg <= HALF_FIRST;
			tx_hold_reg <= 1'b0;
			TX_CHIP_OUT <= 1'b0;
			TX_DATA_TAKE_OUT <= 1'b0;
		end else begin
			TX_DATA_TAKE_OUT <= 1'b0;
			if (TX_CHIP_STROBE_IN) begin
				if (!ctrl_reg.manchester_en) begin
					TX_CHIP_OUT <= TX_DATA_IN;
					TX_DATA_TAKE_OUT <= 1'b1;
					tx_half_reg <= HALF_FIRST;
				end else begin
					case (tx_half_reg)
					HALF_FIRST: begin
						TX_CHIP_OUT <= TX_DATA_IN;
						tx_hold_reg <= TX_DATA_IN;
						tx_half_reg <= HALF_SECOND;
					end
					HALF_SECOND: begin
						TX_CHIP_OUT <= ~tx_hold_reg;
						TX_DATA_TAKE_OUT <= 1'b1;
						tx_half_reg <= HALF_FIRST;
					end
					default: begin
						tx_half_reg <= HALF_FIRST;
					end
					endcase
				end
			end
		end
	end

	// receive chip pairing; a pair of equal chips is a code error.
	// pairing restarts on SYNC_RESTART_IN, so alignment rests on the first chip after it
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rx_half_reg <= HALF_FIRST;
			rx_first_reg <= 1'b0;
		end else if (!ctrl_reg.manchester_en || SYNC_RESTART_IN) begin
			rx_half_reg <= HALF_FIRST;
		end else if (RX_CHIP_STROBE_IN) begin
			case (rx_half_reg)
			HALF_FIRST: begin
				rx_first_reg <= RX_CHIP_IN;
				rx_half_reg <= HALF_SECOND;
			end
			HALF_SECOND: begin
				rx_half_reg <= HALF_FIRST;
			end
			default: begin
				rx_half_reg <= HALF_FIRST;
			end
			endcase
		end
	end

	// decoded bit stream feeding the correlator
	always_comb begin
		if (ctrl_reg.manchester_en) begin
			rx_bit = rx_first_reg;
			rx_bit_valid = RX_CHIP_STROBE_IN && rx_half_reg == HALF_SECOND
				&& !SYNC_RESTART_IN;
		end else begin
			rx_bit = RX_CHIP_IN;
			rx_bit_valid = RX_CHIP_STROBE_IN;
		end
	end

	// decoded data out, with the pair error flag
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			RX_DATA_OUT <= 1'b0;
			RX_DATA_VALID_OUT <= 1'b0;
			RX_CODE_ERR_OUT <= 1'b0;
		end else begin
			RX_DATA_VALID_OUT <= rx_bit_valid;
			RX_CODE_ERR_OUT <= rx_bit_valid && ctrl_reg.manchester_en
				&& (rx_first_reg == RX_CHIP_IN);
			if (rx_bit_valid) begin
				RX_DATA_OUT <= rx_bit;
			end
		end
	end

	sync_correlator #(
		.WORD_W(WORD_W)
	) u_corr (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.clear_in(SYNC_RESTART_IN || hit),
		.bit_in(rx_bit),
		.bit_valid_in(rx_bit_valid),
		.sync_word_in(SYNC_WORD_IN),
		.low_match_out(low_match),
		.full_match_out(full_match),
		.fill_out(fill)
	);

	// qualifier decode; the carrier bit adds to, never replaces, the
	// word criterion, so mode 4 also searches nothing
	always_comb begin
		sync_base = sync_base_e'(ctrl_reg.sync_qualifier[1:0]);
		sync_enabled = sync_base != SYNC_NONE;
		case (sync_base)
		SYNC_15_16: begin
			criterion_met = fill >= SYNC16_LEN
				&& low_match >= SYNC16_LOOSE;
		end
		SYNC_16_16: begin
			criterion_met = fill >= SYNC16_LEN
				&& low_match == SYNC16_LEN;
		end
		SYNC_30_32: begin
			criterion_met = fill >= SYNC32_LEN
				&& full_match >= SYNC32_LOOSE;
		end
		default: begin
			criterion_met = 1'b0;
		end
		endcase
		hit = criterion_met && (!ctrl_reg.sync_qualifier[2]
			|| CARRIER_ABOVE_IN);
	end

	// sync report: one pulse per hit, window restarts after it
	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SYNC_SEARCH_OUT <= 1'b0;
			SYNC_FOUND_OUT <= 1'b0;
		end else begin
			SYNC_SEARCH_OUT <= sync_enabled;
			SYNC_FOUND_OUT <= hit;
		end
	end
endmodule

// ==== test/modem_format_config_assertions.sv ====
// port checks for the modem format register block
// assumes bind to modem_format_config, one clock domain
`timescale 1ns/1ps
module modem_format_config_assertions (
	input wire logic CLK_IN,
	input wire logic RST_IN,
	input wire logic [7:0] REG_ADDR_IN,
	input wire logic REG_WR_IN,
	input wire logic REG_RD_IN,
	input wire logic [7:0] REG_WDATA_IN,
	input wire logic [7:0] REG_RDATA_OUT,
	input wire logic REG_RVALID_OUT,
	input wire logic DC_BLOCK_BYPASS_OUT,
	input wire logic [2:0] MODULATION_SELECT_OUT,
	input wire logic MANCHESTER_EN_OUT,
	input wire logic TX_CHIP_STROBE_IN,
	input wire logic TX_DATA_TAKE_OUT,
	input wire logic SYNC_SEARCH_OUT,
	input wire logic SYNC_FOUND_OUT
);
	import modem_format_pkg::*;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	// mapped write; fields follow two edges later
	wire hit = REG_WR_IN && REG_ADDR_IN == MODEM_FMT_ADDR;
	rd_answer_a: assert property (REG_RD_IN |=> REG_RVALID_OUT)
		else $error("read not answered");
	rd_unmapped_a: assert property (
		REG_RD_IN && REG_ADDR_IN != MODEM_FMT_ADDR
		|=> REG_RDATA_OUT == READ_UNMAPPED)
		else $error("unmapped read not zero");
	bypass_a: assert property (hit |=> ##1
		DC_BLOCK_BYPASS_OUT == $past(REG_WDATA_IN[7], 2))
		else $error("bypass bit wrong");
	mod_sel_a: assert property (hit |=> ##1
		MODULATION_SELECT_OUT == $past(REG_WDATA_IN[6:4], 2))
		else $error("modulation wrong");
	manch_bit_a: assert property (hit |=> ##1
		MANCHESTER_EN_OUT == $past(REG_WDATA_IN[3], 2))
		else $error("manchester bit wrong");
	sync_off_a: assert property (hit |=> ##1
		SYNC_SEARCH_OUT == ($past(REG_WDATA_IN[1:0], 2) != 2'h0))
		else $error("sync search wrong");
	// skip the cycle where a write is still on its way to the output
	tx_plain_a: assert property (TX_CHIP_STROBE_IN &&
		!MANCHESTER_EN_OUT && !$past(hit) |=> TX_DATA_TAKE_OUT)
		else $error("plain chip did not take data");
	found_gate_a: assert property (
		SYNC_FOUND_OUT |-> SYNC_SEARCH_OUT)
		else $error("sync found while search off");
	// a hit empties the window, so a second hit needs a full refill
	found_pulse_a: assert property (
		SYNC_FOUND_OUT |=> !SYNC_FOUND_OUT)
		else $error("sync found twice in a row");
	cover property (hit);
	cover property (SYNC_FOUND_OUT);
	cover property (TX_DATA_TAKE_OUT && MANCHESTER_EN_OUT);
endmodule
bind modem_format_config modem_format_config_assertions chk (
	.CLK_IN(CLK_IN), .RST_IN(RST_IN), .REG_ADDR_IN(REG_ADDR_IN),
	.REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
	.REG_WDATA_IN(REG_WDATA_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
	.REG_RVALID_OUT(REG_RVALID_OUT),
	.DC_BLOCK_BYPASS_OUT(DC_BLOCK_BYPASS_OUT),
	.MODULATION_SELECT_OUT(MODULATION_SELECT_OUT),
	.MANCHESTER_EN_OUT(MANCHESTER_EN_OUT),
	.TX_CHIP_STROBE_IN(TX_CHIP_STROBE_IN),
	.TX_DATA_TAKE_OUT(TX_DATA_TAKE_OUT),
	.SYNC_SEARCH_OUT(SYNC_SEARCH_OUT), .SYNC_FOUND_OUT(SYNC_FOUND_OUT));

// ==== test/host_port_model.sv ====
// host side of the register port: one-cycle write and read strobes
// assumes callers use wr and rd; signals move at falling edges
`timescale 1ns/1ps
module host_port_model #(
	parameter int BAUD_K = 100
) (
	input wire logic clk_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic rd_out,
	output logic [7:0] wdata_out,
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in
);
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		rd_out = 1'b0;
		wdata_out = 8'h00;
	end
	// no async serial mode here, so manchester may be set
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		if (BAUD_K > 250)
			v[7] = 1'b0;
		// never manchester with 4-level fsk
		if (v[6:4] == 3'h4)
			v[3] = 1'b0;
		@(negedge clk_in);
		addr_out = a;
		wdata_out = v;
		wr_out = 1'b1;
		@(negedge clk_in);
		wr_out = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d,
		output logic v);
		@(negedge clk_in);
		addr_out = a;
		rd_out = 1'b1;
		// the valid flag stands for one cycle after the taking edge only; the data holds until the next read
		@(negedge clk_in);
		rd_out = 1'b0;
		d = rdata_in;
		v = rvalid_in;
	endtask
endmodule

// ==== test/tb_modem_format_config.sv ====
// self-checking bench for the modem format register block
// assumes host_port_model drives the register port
`timescale 1ns/1ps
module tb_modem_format_config;
	import modem_format_pkg::*;
	localparam logic [15:0] WORD = 16'hd391;
	// {qualifier, carrier, found, 32 bits, 00, flip mask}
	localparam logic [15:0] CASES [13] = '{16'h4800, 16'h4001, 16'h2801,
		16'h2003, 16'h6c03, 16'h6407, 16'h1400, 16'h9400, 16'hc000,
		16'hd800, 16'hfc03, 16'hb801, 16'he400};
	logic clk = 1'b0, rst = 1'b1, dbit = 1'b0, tx_s = 1'b0, rx_s = 1'b0;
	logic carrier = 1'b0, restart = 1'b0, wr, rd, rvalid, bypass, manch;
	logic tx_chip, take, rx_d, rx_v, rx_err, search, found;
	logic [7:0] addr, wdata, rdata;
	modulation_select_e mods;
	int bad_count = 0, n_compared = 0, cycles = 0;
	initial forever #4 clk = ~clk;
	host_port_model host (.clk_in(clk), .addr_out(addr), .wr_out(wr),
		.rd_out(rd), .wdata_out(wdata), .rdata_in(rdata),
		.rvalid_in(rvalid));
	modem_format_config dut (.CLK_IN(clk), .RST_IN(rst),
		.REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata),
		.REG_RVALID_OUT(rvalid), .DC_BLOCK_BYPASS_OUT(bypass),
		.MODULATION_SELECT_OUT(mods), .MANCHESTER_EN_OUT(manch),
		.TX_DATA_IN(dbit), .TX_CHIP_STROBE_IN(tx_s), .TX_CHIP_OUT(tx_chip),
		.TX_DATA_TAKE_OUT(take), .RX_CHIP_IN(dbit),
		.RX_CHIP_STROBE_IN(rx_s), .RX_DATA_OUT(rx_d),
		.RX_DATA_VALID_OUT(rx_v), .RX_CODE_ERR_OUT(rx_err),
		.SYNC_WORD_IN(WORD), .CARRIER_ABOVE_IN(carrier),
		.SYNC_RESTART_IN(restart), .SYNC_SEARCH_OUT(search),
		.SYNC_FOUND_OUT(found));
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic rdchk(logic [7:0] a, logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.rd(a, d, v);
		chk("rvalid", v, 1);
		chk("rdata", d, e);
	endtask
	// one chip slot; returns at the falling edge after the strobe edge,
	// while the one-cycle pulses that it caused still stand
	task automatic strb(logic t, logic r, logic c);
		@(negedge clk);
		dbit = c;
		tx_s = t;
		rx_s = r;
		@(negedge clk);
		tx_s = 1'b0;
		rx_s = 1'b0;
	endtask
	task automatic t_reset();
		chk("search", search, 1);
		chk("fields", {bypass, mods, manch}, 0);
		host.wr(8'h13, 8'hff);
		rdchk(8'h13, READ_UNMAPPED);
		rdchk(MODEM_FMT_ADDR, MODEM_FMT_RESET);
	endtask
	// every modulation and qualifier code, reserved ones too
	task automatic t_fields();
		logic [2:0] m;
		for (int i = 0; i < 8; i++) begin
			m = i[2:0];
			host.wr(MODEM_FMT_ADDR, {m[0], m, m[1], m});
			repeat (2) @(negedge clk);
			chk("bypass", bypass, m[0]);
			chk("mod", mods, m);
			chk("manch", manch, m[1]);
			chk("search", search, m[1:0] != 2'h0);
			rdchk(MODEM_FMT_ADDR, {m[0], m, m[1], m});
		end
	endtask
	// manchester on, a restart in mid-pair, then plain chips
	task automatic t_manch();
		host.wr(MODEM_FMT_ADDR, 8'h0a);
		repeat (2) @(negedge clk);
		strb(1, 0, 1);
		chk("chip take", {tx_chip, take}, 2'b10);
		strb(1, 0, 1);
		chk("chip take", {tx_chip, take}, 2'b01);
		strb(0, 1, 1);
		strb(0, 1, 0);
		chk("rx", {rx_v, rx_d, rx_err}, 3'b110);
		strb(0, 1, 1);
		strb(0, 1, 1);
		chk("rx", {rx_v, rx_d, rx_err}, 3'b111);
		// restart drops the half pair, so the next chip opens a new one
		strb(0, 1, 1);
		restart = 1'b1;
		@(negedge clk);
		restart = 1'b0;
		strb(0, 1, 0);
		chk("rx first", rx_v, 0);
		strb(0, 1, 1);
		chk("rx", {rx_v, rx_d, rx_err}, 3'b100);
		host.wr(MODEM_FMT_ADDR, 8'h02);
		repeat (2) @(negedge clk);
		strb(1, 0, 0);
		chk("plain take", {tx_chip, take}, 2'b01);
		strb(0, 1, 1);
		chk("plain rx", {rx_v, rx_d, rx_err}, 3'b110);
	endtask
	// oldest bit first; bit k from the newest is checked against word[k%16]
	task automatic t_sync();
		logic [15:0] e;
		logic [31:0] fl;
		logic seen;
		int n;
		foreach (CASES[i]) begin
			e = CASES[i];
			fl = {24'h0, e[7:0]};
			n = e[10] ? 32 : 16;
			host.wr(MODEM_FMT_ADDR, {5'h00, e[15:13]});
			carrier = e[12];
			@(negedge clk);
			restart = 1'b1;
			@(negedge clk);
			restart = 1'b0;
			for (int k = n - 1; k >= 0; k--)
				strb(0, 1, WORD[k % 16] ^ fl[k]);
			seen = 1'b0;
			repeat (4) begin
				seen = seen | found;
				@(negedge clk);
			end
			chk("found", seen, e[11]);
		end
	endtask
	// reset in mid-run drops a written value back to the reset state
	task automatic t_rereset();
		host.wr(MODEM_FMT_ADDR, 8'hff);
		repeat (2) @(negedge clk);
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_reset();
	endtask
	// hang guard, well above the fewer than a thousand cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (2) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		t_reset();
		t_fields();
		t_manch();
		t_sync();
		t_rereset();
		give_verdict();
	end
endmodule
